// ### mshic_pkg.sv
package mshic_pkg;

  // register offsets (byte addresses on apb)
  localparam logic [7:0] MSHIC_OFS_R10       = 8'h00;
  localparam logic [7:0] MSHIC_OFS_R11       = 8'h04;
  localparam logic [7:0] MSHIC_OFS_R12       = 8'h08;
  localparam logic [7:0] MSHIC_OFS_R13       = 8'h0c;
  localparam logic [7:0] MSHIC_OFS_R14       = 8'h10;
  localparam logic [7:0] MSHIC_OFS_STATUS    = 8'h14;
  localparam logic [7:0] MSHIC_OFS_VTUNE     = 8'h18;

  // writable masks: only documented fields store, the rest read zero
  localparam logic [31:0] MSHIC_MASK_R10     = 32'h0000_1fe0;
  localparam logic [31:0] MSHIC_MASK_R11     = 32'hffff_f020;
  localparam logic [31:0] MSHIC_MASK_R12     = 32'hffc0_01c0;
  localparam logic [31:0] MSHIC_MASK_R13     = 32'hff7f_ff60;
  localparam logic [31:0] MSHIC_MASK_R14     = 32'hd73f_cfe0;
  localparam logic [31:0] MSHIC_MASK_VTUNE   = 32'h0000_0001;

  // reset values
  localparam logic [31:0] MSHIC_RST_R10      = 32'h0000_0200;
  localparam logic [31:0] MSHIC_RST_R11      = 32'h0581_1000;
  localparam logic [31:0] MSHIC_RST_R12      = 32'h1b00_0180;
  localparam logic [31:0] MSHIC_RST_R13      = 32'h3b02_0660;
  localparam logic [31:0] MSHIC_RST_R14      = 32'h1200_0000;

  // field positions
  localparam int MSHIC_R10_OSC_SEL           = 12;
  localparam int MSHIC_R10_FB_EN             = 11;
  localparam int MSHIC_R10_FB_SEL_LSB        = 5;
  localparam int MSHIC_R11_NOSYNC_LSB        = 20;
  localparam int MSHIC_R11_ALIGN_OUT_LSB     = 18;
  localparam int MSHIC_R11_ALIGN_QUAL        = 17;
  localparam int MSHIC_R11_ALIGN_POL         = 16;
  localparam int MSHIC_R11_ALIGN_AUTO        = 15;
  localparam int MSHIC_R11_XTAL_EN           = 5;
  localparam int MSHIC_R12_LOCK_SRC_LSB      = 27;
  localparam int MSHIC_R12_HOLD_B            = 23;
  localparam int MSHIC_R12_HOLD_A            = 22;
  localparam int MSHIC_R12_TRACK             = 8;
  localparam int MSHIC_R12_HOLDOVER_LSB      = 6;
  localparam int MSHIC_R13_STAT1_LSB         = 20;
  localparam int MSHIC_R13_IGN_UNLOCK        = 15;
  localparam int MSHIC_R13_STAT0_LSB         = 12;
  localparam int MSHIC_R13_REF_MODE_LSB      = 9;
  localparam int MSHIC_R13_INVERT            = 8;
  localparam int MSHIC_R13_REF1_EN           = 6;
  localparam int MSHIC_R13_REF0_EN           = 5;
  localparam int MSHIC_R14_LOS_TMO_LSB       = 30;
  localparam int MSHIC_R14_LOS_EN            = 28;

  localparam logic [2:0] MSHIC_REF_MODE_PIN  = 3'h6;
  localparam logic [1:0] MSHIC_HOLDOVER_ON   = 2'h2;

  // loss-of-signal timeouts, 50 mhz clock
  localparam int MSHIC_CLK_NS                = 20;
  localparam int MSHIC_LOS_T0_NS             = 1200;
  localparam int MSHIC_LOS_T0_CYC            = MSHIC_LOS_T0_NS / MSHIC_CLK_NS;
  localparam logic [9:0] MSHIC_LOS_T0        = 10'(MSHIC_LOS_T0_CYC);

endpackage

// ### mshic_los_det.sv
`timescale 1ns/1ns
module mshic_los_det
  import mshic_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic [1:0] timeout_sel,
  input  wire logic       ref_sync,
  output logic            lost
);

  typedef struct packed {
    logic       prev;
    logic [12:0] cnt;
    logic       lost;
  } mshic_los_s;

  mshic_los_s st_reg;
  mshic_los_s st_next;
  logic [12:0] limit;

  // longer codes double the window; only code zero has a fixed figure
  assign limit = 13'(MSHIC_LOS_T0) << timeout_sel;

  always_comb begin
    st_next      = st_reg;
    st_next.prev = ref_sync;
    if (!enable || (ref_sync != st_reg.prev)) begin
      st_next.cnt  = '0;
      st_next.lost = 1'b0;
    end else if (st_reg.cnt >= limit - 13'h1) begin
      st_next.lost = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 13'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lost = st_reg.lost;

endmodule

// ### mshic_sync2.sv
`timescale 1ns/1ns
module mshic_sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ### mshic_top.sv
// Overview of operation
// - bit 12 of r10 picks raw oscillator or divider; reset raw.
// - feedback mux stays powered down while r10 bit 11 is zero.
// - r10 bits 7:5 pick output feeding first loop divider; reset output zero.
// - r11 bits 25:20 exclude pairs from alignment; reset excludes 24 and 23.
// - r11 bits 19:18 pick align pin output source; reset drives low.
// - r11 bit 17 qualifies alignment with a clock output; reset off.
// - r11 bit 16 sets align input polarity; reset one, active low.
// - with r11 bit 15 clear, writes to r0..r5 start no alignment.
// - r11 bit 5 enables second loop crystal oscillator; reset disabled.
// - r12 bits 31:27 pick lock pin source; reset 3, both loops locked.
// - r12 bit 23 holds alignment until second loop locks.
// - r12 bit 22 holds alignment until first loop locks.
// - r12 bit 8 enables dac tracking of first loop; reset enabled.
// - r12 bits 7:6 at value 2 enter holdover on lock loss.
// - r13 bit 15 set ignores first loop unlock edge for holdover.
// - r13 bits 11:9 pick reference choice mode; reset 3, manual.
// - r13 bit 8 inverts status inputs, only when mode equals 6.
// - reference one usable only while r13 bit 6 is set.
// - reference zero usable only while r13 bit 5 is set.
// - r14 bits 31:30 set loss-of-signal timeout; zero means 1200 ns.
// - loss-of-signal detection active only while r14 bit 28 is set.
// - r13 bits 22:20 and 14:12 pick status pin sources; reset low.
// - with rail trip enable set and r12 bits 7:6 at 2, reaching a trip voltage enters holdover.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
module mshic_top
  import mshic_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        align_pin_in,
  input  wire logic        loop_a_lock,
  input  wire logic        loop_b_lock,
  input  wire logic        vtune_trip,
  input  wire logic        ref0_clk,
  input  wire logic        ref1_clk,
  input  wire logic        status_pin0_in,
  input  wire logic        status_pin1_in,
  input  wire logic        output_reg_write,
  output logic             osc_output_select,
  output logic             feedback_mux_powered,
  output logic [2:0]       feedback_select,
  output logic [5:0]       exclude_pairs_from_align,
  output logic             align_qualify,
  output logic             second_loop_crystal_enable,
  output logic             dac_track_enable,
  output logic [2:0]       reference_choice_mode,
  output logic             align_active,
  output logic             align_pin_out,
  output logic             lock_pin_out,
  output logic             status_pin0_out,
  output logic             status_pin1_out,
  output logic             holdover_active,
  output logic             ref0_usable,
  output logic             ref1_usable,
  output logic             ref0_lost,
  output logic             ref1_lost,
  output logic             status_sel0,
  output logic             status_sel1
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] r10;
    logic [31:0] r11;
    logic [31:0] r12;
    logic [31:0] r13;
    logic [31:0] r14;
    logic        vtune_en;
    logic        lock_a_d;
    logic        holdover;
    logic        align;
    logic        align_in_d;
    logic [31:0] rdata;
  } mshic_state_s;

  mshic_state_s st_reg;
  mshic_state_s st_next;

  logic [7:0] pin_sync;
  logic       access;
  logic       wr_en;
  logic       hit;
  logic       lost0;
  logic       lost1;
  logic       ali_in;
  logic       lock_a;
  logic       lock_b;
  logic       inv;
  logic [31:0] rd_val;

  function automatic logic [31:0] mshic_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [31:0] mask);
    mshic_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic mshic_mux_src(input logic [4:0] sel,
                                         input logic       a_lock,
                                         input logic       b_lock,
                                         input logic       hold);
    case (sel)
      5'h00:   mshic_mux_src = 1'b0;
      5'h01:   mshic_mux_src = a_lock;
      5'h02:   mshic_mux_src = b_lock;
      5'h03:   mshic_mux_src = a_lock & b_lock;
      5'h04:   mshic_mux_src = hold;
      default: mshic_mux_src = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pins from outside, all but output_reg_write, pass two flops before use
  mshic_sync2 #(.W(8)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({align_pin_in, loop_a_lock, loop_b_lock, vtune_trip,
                ref0_clk, ref1_clk, status_pin0_in, status_pin1_in}),
    .q       (pin_sync)
  );

  assign ali_in = pin_sync[7];
  assign lock_a = pin_sync[6];
  assign lock_b = pin_sync[5];

  mshic_los_det u_los0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (st_reg.r14[MSHIC_R14_LOS_EN] & st_reg.r13[MSHIC_R13_REF0_EN]),
    .timeout_sel (st_reg.r14[MSHIC_R14_LOS_TMO_LSB +: 2]),
    .ref_sync    (pin_sync[3]),
    .lost        (lost0)
  );

  mshic_los_det u_los1 (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (st_reg.r14[MSHIC_R14_LOS_EN] & st_reg.r13[MSHIC_R13_REF1_EN]),
    .timeout_sel (st_reg.r14[MSHIC_R14_LOS_TMO_LSB +: 2]),
    .ref_sync    (pin_sync[2]),
    .lost        (lost1)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb: zero wait states, unmapped addresses answer pslverr
  assign access  = psel & penable;
  assign wr_en   = access & pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = st_reg.rdata;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == MSHIC_OFS_R10) begin
      rd_val = st_reg.r10;
    end else if (paddr == MSHIC_OFS_R11) begin
      rd_val = st_reg.r11;
    end else if (paddr == MSHIC_OFS_R12) begin
      rd_val = st_reg.r12;
    end else if (paddr == MSHIC_OFS_R13) begin
      rd_val = st_reg.r13;
    end else if (paddr == MSHIC_OFS_R14) begin
      rd_val = st_reg.r14;
    end else if (paddr == MSHIC_OFS_STATUS) begin
      rd_val = {24'h000000, ref1_lost, ref0_lost, st_reg.align, st_reg.holdover,
                lock_b, lock_a, ref1_usable, ref0_usable};
    end else if (paddr == MSHIC_OFS_VTUNE) begin
      rd_val = {31'h00000000, st_reg.vtune_en};
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next            = st_reg;
    st_next.lock_a_d   = lock_a;
    st_next.align_in_d = ali_in;
    // read data is latched in the setup cycle so it is stable at access
    if (psel && !penable) begin
      st_next.rdata = rd_val;
    end
    if (wr_en) begin
      if (paddr == MSHIC_OFS_R10) begin
        st_next.r10 = mshic_merge(st_reg.r10, pwdata, MSHIC_MASK_R10);
      end else if (paddr == MSHIC_OFS_R11) begin
        st_next.r11 = mshic_merge(st_reg.r11, pwdata, MSHIC_MASK_R11);
      end else if (paddr == MSHIC_OFS_R12) begin
        st_next.r12 = mshic_merge(st_reg.r12, pwdata, MSHIC_MASK_R12);
      end else if (paddr == MSHIC_OFS_R13) begin
        st_next.r13 = mshic_merge(st_reg.r13, pwdata, MSHIC_MASK_R13);
      end else if (paddr == MSHIC_OFS_R14) begin
        st_next.r14 = mshic_merge(st_reg.r14, pwdata, MSHIC_MASK_R14);
      end else if (paddr == MSHIC_OFS_VTUNE) begin
        st_next.vtune_en = pwdata[0];
      end
    end

    // holdover: entered on unlock or rail trip, left once lock returns with the trip pin low
    if (st_reg.r12[MSHIC_R12_HOLDOVER_LSB +: 2] == MSHIC_HOLDOVER_ON) begin
      if ((st_reg.lock_a_d && !lock_a && !st_reg.r13[MSHIC_R13_IGN_UNLOCK])
          || (st_reg.vtune_en && pin_sync[4])) begin
        st_next.holdover = 1'b1;
      end else if (lock_a && !pin_sync[4]) begin
        st_next.holdover = 1'b0;
      end
    end else begin
      st_next.holdover = 1'b0;
    end

    // alignment: pin edge, or auto start on output register write
    if ((ali_in ^ st_reg.r11[MSHIC_R11_ALIGN_POL])
        && !(st_reg.align_in_d ^ st_reg.r11[MSHIC_R11_ALIGN_POL])) begin
      st_next.align = 1'b1;
    end else if (output_reg_write && st_reg.r11[MSHIC_R11_ALIGN_AUTO]) begin
      st_next.align = 1'b1;
    end else if ((st_reg.r12[MSHIC_R12_HOLD_B] && !lock_b)
                 || (st_reg.r12[MSHIC_R12_HOLD_A] && !lock_a)) begin
      st_next.align = 1'b1;
    end else begin
      st_next.align = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.r10      <= MSHIC_RST_R10;
      st_reg.r11      <= MSHIC_RST_R11;
      st_reg.r12      <= MSHIC_RST_R12;
      st_reg.r13      <= MSHIC_RST_R13;
      st_reg.r14      <= MSHIC_RST_R14;
      // synced pin reads low after reset; a low prev keeps that from looking like an edge
      st_reg.align_in_d <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // config outputs come straight from the register flops
  assign osc_output_select          = st_reg.r10[MSHIC_R10_OSC_SEL];
  assign feedback_mux_powered       = st_reg.r10[MSHIC_R10_FB_EN];
  assign feedback_select            = st_reg.r10[MSHIC_R10_FB_SEL_LSB +: 3];
  assign exclude_pairs_from_align   = st_reg.r11[MSHIC_R11_NOSYNC_LSB +: 6];
  assign align_qualify              = st_reg.r11[MSHIC_R11_ALIGN_QUAL];
  assign second_loop_crystal_enable = st_reg.r11[MSHIC_R11_XTAL_EN];
  assign dac_track_enable           = st_reg.r12[MSHIC_R12_TRACK];
  assign reference_choice_mode      = st_reg.r13[MSHIC_R13_REF_MODE_LSB +: 3];
  assign align_active               = st_reg.align;
  assign holdover_active            = st_reg.holdover;
  assign ref0_usable                = st_reg.r13[MSHIC_R13_REF0_EN];
  assign ref1_usable                = st_reg.r13[MSHIC_R13_REF1_EN];
  assign ref0_lost                  = lost0;
  assign ref1_lost                  = lost1;

  assign align_pin_out  = mshic_mux_src({3'h0, st_reg.r11[MSHIC_R11_ALIGN_OUT_LSB +: 2]},
                                        lock_a, lock_b, st_reg.holdover);
  assign lock_pin_out   = mshic_mux_src(st_reg.r12[MSHIC_R12_LOCK_SRC_LSB +: 5],
                                        lock_a, lock_b, st_reg.holdover);
  assign status_pin0_out = mshic_mux_src({2'h0, st_reg.r13[MSHIC_R13_STAT0_LSB +: 3]},
                                         lock_a, lock_b, st_reg.holdover);
  assign status_pin1_out = mshic_mux_src({2'h0, st_reg.r13[MSHIC_R13_STAT1_LSB +: 3]},
                                         lock_a, lock_b, st_reg.holdover);

  // inversion only counts in pin-select reference mode
  assign inv = st_reg.r13[MSHIC_R13_INVERT]
               && (st_reg.r13[MSHIC_R13_REF_MODE_LSB +: 3] == MSHIC_REF_MODE_PIN);
  assign status_sel0 = pin_sync[1] ^ inv;
  assign status_sel1 = pin_sync[0] ^ inv;

endmodule

// ### mshic_top_chk.sv
`timescale 1ns/1ns
module mshic_top_chk
  import mshic_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        osc_output_select,
  input wire logic        feedback_mux_powered,
  input wire logic [2:0]  feedback_select,
  input wire logic [5:0]  exclude_pairs_from_align,
  input wire logic        align_qualify,
  input wire logic        second_loop_crystal_enable,
  input wire logic        dac_track_enable,
  input wire logic [2:0]  reference_choice_mode,
  input wire logic        ref0_usable,
  input wire logic        ref1_usable,
  input wire logic        status_pin0_in,
  input wire logic        status_sel0,
  input wire logic        ref0_clk,
  input wire logic        ref0_lost,
  input wire logic        holdover_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // write strobes per register; age keeps the sync checks off the first edges after reset
  logic       wr10, wr11, wr12, wr13;
  logic [1:0] age;
  logic [9:0] quiet0;
  logic       ref0_prev;
  assign wr10 = psel && penable && pwrite && (paddr == MSHIC_OFS_R10);
  assign wr11 = psel && penable && pwrite && (paddr == MSHIC_OFS_R11);
  assign wr12 = psel && penable && pwrite && (paddr == MSHIC_OFS_R12);
  assign wr13 = psel && penable && pwrite && (paddr == MSHIC_OFS_R13);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age       <= 2'h0;
      quiet0    <= 10'h000;
      ref0_prev <= 1'b0;
    end else begin
      age       <= (age == 2'h3) ? age : age + 2'h1;
      ref0_prev <= ref0_clk;
      quiet0    <= (ref0_clk != ref0_prev) ? 10'h000 : ((quiet0 == 10'h3ff) ? quiet0 : quiet0 + 10'h001);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_osc_sel_write: assert property (wr10 |=> osc_output_select == $past(pwdata[12]))
    else $error("oscillator select does not follow write");
  chk_fb_power_write: assert property (wr10 |=> feedback_mux_powered == $past(pwdata[11]))
    else $error("feedback mux power does not follow write");
  chk_fb_select_write: assert property (wr10 |=> feedback_select == $past(pwdata[7:5]))
    else $error("feedback select does not follow write");
  chk_exclude_pairs_write: assert property (wr11 |=> exclude_pairs_from_align == $past(pwdata[25:20]))
    else $error("pair exclusion does not follow write");
  chk_qualify_write: assert property (wr11 |=> align_qualify == $past(pwdata[17]))
    else $error("align qualify does not follow write");
  chk_crystal_write: assert property (wr11 |=> second_loop_crystal_enable == $past(pwdata[5]))
    else $error("crystal enable does not follow write");
  chk_track_write: assert property (wr12 |=> dac_track_enable == $past(pwdata[8]))
    else $error("dac tracking does not follow write");
  chk_ref_mode_write: assert property (wr13 |=> reference_choice_mode == $past(pwdata[11:9])
    && ref0_usable == $past(pwdata[5]) && ref1_usable == $past(pwdata[6]))
    else $error("reference selection fields do not follow write");
  chk_status_plain: assert property (age == 2'h3 && reference_choice_mode != MSHIC_REF_MODE_PIN
    && $past(status_pin0_in, 1) == $past(status_pin0_in, 2) && $past(status_pin0_in, 2) == $past(status_pin0_in, 3)
    |-> status_sel0 == $past(status_pin0_in))
    else $error("status input inverted outside pin select mode");
  chk_loss_quiet: assert property ($rose(ref0_lost) |-> quiet0 >= 10'd56)
    else $error("loss of signal raised before the timeout");
  cover property (wr13);
  cover property ($rose(ref0_lost));
  cover property ($rose(holdover_active));
endmodule

bind mshic_top mshic_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .osc_output_select(osc_output_select), .feedback_mux_powered(feedback_mux_powered),
  .feedback_select(feedback_select), .exclude_pairs_from_align(exclude_pairs_from_align),
  .align_qualify(align_qualify), .second_loop_crystal_enable(second_loop_crystal_enable),
  .dac_track_enable(dac_track_enable), .reference_choice_mode(reference_choice_mode), .ref0_usable(ref0_usable),
  .ref1_usable(ref1_usable), .status_pin0_in(status_pin0_in), .status_sel0(status_sel0), .ref0_clk(ref0_clk),
  .ref0_lost(ref0_lost), .holdover_active(holdover_active));

// ### mshic_top_tb.sv
`timescale 1ns/1ns
module mshic_top_tb
  import mshic_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run0 = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic align_pin_in = 1'b1, loop_a_lock = 1'b1, loop_b_lock = 1'b1, vtune_trip = 1'b0, ref0_clk = 1'b0;
  logic ref1_clk = 1'b0, status_pin0_in = 1'b0, status_pin1_in = 1'b0, output_reg_write = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, osc_output_select, feedback_mux_powered, align_qualify, second_loop_crystal_enable;
  logic [2:0]  feedback_select, reference_choice_mode;
  logic [5:0]  exclude_pairs_from_align;
  logic dac_track_enable, align_active, align_pin_out, lock_pin_out, status_pin0_out, status_pin1_out;
  logic holdover_active, ref0_usable, ref1_usable, ref0_lost, ref1_lost, status_sel0, status_sel1;
  int fails = 0;
  int total_checks = 0;
  // reset values worked out field by field from the defaults table
  logic [31:0] dft [5] = '{32'h0000_0200, 32'h0581_1000, 32'h1b00_0180, 32'h3b02_0660, 32'h1200_0000};
  logic [31:0] msk [5] = '{MSHIC_MASK_R10, MSHIC_MASK_R11, MSHIC_MASK_R12, MSHIC_MASK_R13, MSHIC_MASK_R14};
  logic [7:0]  ofs [5] = '{MSHIC_OFS_R10, MSHIC_OFS_R11, MSHIC_OFS_R12, MSHIC_OFS_R13, MSHIC_OFS_R14};
  wire  [18:0] cfg = {osc_output_select, feedback_mux_powered, feedback_select, exclude_pairs_from_align, align_qualify,
                      second_loop_crystal_enable, dac_track_enable, reference_choice_mode, ref1_usable, ref0_usable};

  mshic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .align_pin_in(align_pin_in),
    .loop_a_lock(loop_a_lock), .loop_b_lock(loop_b_lock), .vtune_trip(vtune_trip), .ref0_clk(ref0_clk),
    .ref1_clk(ref1_clk), .status_pin0_in(status_pin0_in), .status_pin1_in(status_pin1_in),
    .output_reg_write(output_reg_write), .osc_output_select(osc_output_select),
    .feedback_mux_powered(feedback_mux_powered), .feedback_select(feedback_select),
    .exclude_pairs_from_align(exclude_pairs_from_align), .align_qualify(align_qualify),
    .second_loop_crystal_enable(second_loop_crystal_enable), .dac_track_enable(dac_track_enable),
    .reference_choice_mode(reference_choice_mode), .align_active(align_active), .align_pin_out(align_pin_out),
    .lock_pin_out(lock_pin_out), .status_pin0_out(status_pin0_out), .status_pin1_out(status_pin1_out),
    .holdover_active(holdover_active), .ref0_usable(ref0_usable), .ref1_usable(ref1_usable),
    .ref0_lost(ref0_lost), .ref1_lost(ref1_lost), .status_sel0(status_sel0), .status_sel1(status_sel1));

  always #10 pclk = ~pclk;
  // reference clocks toggle every cycle; run0 lets a scenario stop reference zero
  always @(posedge pclk) begin
    if (run0) ref0_clk <= ~ref0_clk;
    ref1_clk <= ~ref1_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; waits for pready under a bounded count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check("register read", r, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(6000);
    fails++;
    give_verdict();
  end
  initial begin
    logic [31:0] r;
    logic e;
    wt(2);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i], dft[i]);
    check("config outputs", 32'(cfg), 32'({5'h00, 6'h18, 3'h1, 3'h3, 2'h3}));
    check("pin outputs", 32'({lock_pin_out, align_pin_out, status_pin1_out, status_pin0_out}), 32'h8);
    for (int i = 0; i < 5; i++) wr(ofs[i], 32'hffff_ffff);
    check("config ones", 32'(cfg), 32'h0007_ffff);
    for (int i = 0; i < 5; i++) rd(ofs[i], msk[i]);
    for (int i = 0; i < 5; i++) wr(ofs[i], 32'h0);
    check("config zeros", 32'(cfg), 32'h0);
    for (int i = 0; i < 5; i++) wr(ofs[i], dft[i]);
    apb(1'b1, 8'h1c, 32'hffff_ffff, r, e);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped data", r, 32'h0);
    rd(MSHIC_OFS_R14, dft[4]);
    // lock pin follows both loops together
    loop_b_lock <= 1'b0;
    wt(5);
    check("lock pin", 32'(lock_pin_out), 32'h0);
    loop_b_lock <= 1'b1;
    // with automatic start off, an output register write starts nothing
    output_reg_write <= 1'b1;
    wt(1);
    output_reg_write <= 1'b0;
    wt(5);
    check("align after write", 32'(align_active), 32'h0);
    // inversion only counts in pin select mode
    status_pin0_in <= 1'b1;
    wr(MSHIC_OFS_R13, 32'h3b02_0760);
    wt(4);
    check("status plain", 32'({status_sel1, status_sel0}), 32'h1);
    wr(MSHIC_OFS_R13, 32'h3b02_0d60);
    wt(2);
    check("status invert", 32'({status_sel1, status_sel0}), 32'h2);
    wr(MSHIC_OFS_R13, dft[3]);
    // holdover on unlock, ignored when the edge is masked, and on a rail trip
    loop_a_lock <= 1'b0;
    wt(6);
    check("holdover entry", 32'(holdover_active), 32'h1);
    loop_a_lock <= 1'b1;
    wt(6);
    check("holdover exit", 32'(holdover_active), 32'h0);
    wr(MSHIC_OFS_R13, 32'h3b02_8660);
    loop_a_lock <= 1'b0;
    wt(6);
    check("holdover masked", 32'(holdover_active), 32'h0);
    loop_a_lock <= 1'b1;
    wr(MSHIC_OFS_R13, dft[3]);
    wr(MSHIC_OFS_VTUNE, 32'h1);
    vtune_trip <= 1'b1;
    wt(6);
    check("rail trip", 32'(holdover_active), 32'h1);
    vtune_trip <= 1'b0;
    wr(MSHIC_OFS_VTUNE, 32'h0);
    // loss of signal: 60 cycles at code zero, 120 at code one, cleared when disabled
    check("running ref", 32'(ref0_lost), 32'h0);
    run0 <= 1'b0;
    wt(50);
    check("early loss", 32'(ref0_lost), 32'h0);
    wt(25);
    check("loss code zero", 32'(ref0_lost), 32'h1);
    wr(MSHIC_OFS_R14, 32'h0200_0000);
    wt(5);
    check("loss disabled", 32'(ref0_lost), 32'h0);
    wr(MSHIC_OFS_R14, 32'h5200_0000);
    run0 <= 1'b1;
    wt(20);
    run0 <= 1'b0;
    wt(100);
    check("early loss one", 32'(ref0_lost), 32'h0);
    wt(40);
    check("loss code one", 32'(ref0_lost), 32'h1);
    give_verdict();
  end
endmodule
